// ===== hw/rtc_core.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - ten locations: time, alarms, calendar, bin/BCD
// - alarm, periodic and update-ended event sources
// - each source gated by its enable bit
// - enabling a set flag raises request at once
// - events set flags regardless of enables
// - status read clears flags set at read
// - status double latched; events during read held
// - request low while any flag-enable pair set
// - status bit 7 mirrors active request
// - status read clears summary bit too
// - oscillator off in initial condition
// - pattern 010 runs oscillator and chain
// - pattern 11x runs oscillator, chain held
// - any other pattern stops oscillator
// - rate bits pick divider tap for square wave
// - square wave and periodic share selector
// - square wave gated by own enable
// - periodic interval 122 us to 500 ms
// - periodic and alarm have separate enables
// - alarm byte 11xxxxxx matches anything
// - 12-hour mode: hours bit 7 is pm
// - rate 0000 disables square wave and periodic
// - reset clears enables, flags, floats request
module rtc_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic osc_tick,
    input wire rtc_pkg::rtc_bus_s bus,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic irq_n_out,
    output logic irq_oe,
    output logic square_out_pin
);
    import rtc_pkg::*;

    rtc_state_s q;
    rtc_state_s d;
    logic [2:0] ev;
    logic irq;
    logic osc_hold;
    logic tick_en;
    logic sec_pulse;
    logic [3:0] rate;
    logic [3:0] tap_sel;
    logic [14:0] tap_mask;
    logic wr_edge;
    logic rd_start;
    logic rd_end;
    logic [7:0] rd_val;
    logic [9:0][7:0] adv;
    logic alarm_hit;
    logic bin;
    logic pm;
    logic day_carry;
    logic [7:0] s_b;
    logic [7:0] m_b;
    logic [7:0] h_b;
    logic [7:0] w_b;
    logic [7:0] dt_b;
    logic [7:0] mo_b;
    logic [7:0] y_b;
    logic [7:0] h_enc;

    // ********************************
    // helpers
    // ********************************
    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic b);
        to_bin = b ? v : ({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]};
    endfunction : to_bin

    function automatic logic [7:0] from_bin(input logic [7:0] v, input logic b);
        from_bin = b ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
    endfunction : from_bin

    // leap years taken as every fourth year, good through 2099
    function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] y);
        case (mo)
            8'h02: month_days = (y[1:0] == 2'h0) ? 8'd29 : 8'd28;
            8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'd30;
            default: month_days = 8'd31;
        endcase
    endfunction : month_days

    function automatic logic alarm_match(input logic [7:0] a, input logic [7:0] t);
        alarm_match = (a[7:6] == ALARM_DONT_CARE) || (a == t);
    endfunction : alarm_match

    // rates 1 and 2 alias the 256 Hz and 128 Hz taps
    function automatic logic [3:0] tap_of(input logic [3:0] rs);
        case (rs)
            4'h1: tap_of = 4'h6;
            4'h2: tap_of = 4'h7;
            default: tap_of = 4'(rs - 4'h2);
        endcase
    endfunction : tap_of

    // ********************************
    // oscillator, divider and taps
    // ********************************
    assign rate = q.ra[3:0];
    assign osc_hold = (q.ra[6:5] == OSC_HOLD);
    assign tick_en = ce && osc_tick && (q.ra[6:4] == OSC_RUN);
    assign sec_pulse = tick_en && (&q.div);
    assign tap_sel = tap_of(rate);
    assign tap_mask = 15'((16'h2 << tap_sel) - 16'h1);
    // periodic event on the falling edge of the tap, 122 us .. 500 ms
    assign ev[F_PERIODIC] = tick_en && (rate != 4'h0)
        && ((q.div & tap_mask) == tap_mask);
    assign ev[F_UPDATE] = sec_pulse;
    assign ev[F_ALARM] = sec_pulse && alarm_hit;

    // ********************************
    // bus strobes
    // ********************************
    assign wr_edge = q.wr_low && bus.wr_n && !bus.sel_n;
    assign rd_start = !q.rd_low && !bus.rd_n && !bus.sel_n && bus.a0
        && (q.index == OFS_EVENT_STATUS);
    assign rd_end = q.reading && bus.rd_n;

    // ********************************
    // once-a-second advance
    // ********************************
    always_comb begin
        bin = q.rb[RB_BINARY];
        adv = q.tk;
        day_carry = 1'b0;
        pm = q.tk[OFS_HOURS_COUNT][7];
        s_b = to_bin(q.tk[OFS_SECONDS_COUNT], bin);
        m_b = to_bin(q.tk[OFS_MINUTES_COUNT], bin);
        h_b = q.rb[RB_H24] ? to_bin(q.tk[OFS_HOURS_COUNT], bin)
            : to_bin({1'b0, q.tk[OFS_HOURS_COUNT][6:0]}, bin);
        w_b = q.tk[OFS_WEEKDAY_COUNT];
        dt_b = to_bin(q.tk[OFS_DAY_OF_MONTH], bin);
        mo_b = to_bin(q.tk[OFS_MONTH_COUNT], bin);
        y_b = to_bin(q.tk[OFS_YEAR_COUNT], bin);
        if (s_b >= 8'd59) begin
            s_b = 8'd0;
            if (m_b >= 8'd59) begin
                m_b = 8'd0;
                if (q.rb[RB_H24]) begin
                    day_carry = (h_b >= 8'd23);
                    h_b = day_carry ? 8'd0 : h_b + 8'd1;
                end else if (h_b >= 8'd12) begin
                    h_b = 8'd1;
                end else if (h_b == 8'd11) begin
                    h_b = 8'd12;
                    pm = !pm;
                    day_carry = !pm;
                end else begin
                    h_b = h_b + 8'd1;
                end
            end else begin
                m_b = m_b + 8'd1;
            end
        end else begin
            s_b = s_b + 8'd1;
        end
        if (day_carry) begin
            w_b = (w_b >= 8'd7) ? 8'd1 : w_b + 8'd1;
            if (dt_b >= month_days(mo_b, y_b)) begin
                dt_b = 8'd1;
                if (mo_b >= 8'd12) begin
                    mo_b = 8'd1;
                    y_b = (y_b >= 8'd99) ? 8'd0 : y_b + 8'd1;
                end else begin
                    mo_b = mo_b + 8'd1;
                end
            end else begin
                dt_b = dt_b + 8'd1;
            end
        end
        h_enc = from_bin(h_b, bin);
        if (!q.rb[RB_SET]) begin
            adv[OFS_SECONDS_COUNT] = from_bin(s_b, bin);
            adv[OFS_MINUTES_COUNT] = from_bin(m_b, bin);
            adv[OFS_HOURS_COUNT] = q.rb[RB_H24] ? h_enc
                : {pm, h_enc[6:0]};
            adv[OFS_WEEKDAY_COUNT] = w_b;
            adv[OFS_DAY_OF_MONTH] = from_bin(dt_b, bin);
            adv[OFS_MONTH_COUNT] = from_bin(mo_b, bin);
            adv[OFS_YEAR_COUNT] = from_bin(y_b, bin);
        end
        alarm_hit = alarm_match(q.tk[OFS_SECONDS_ALARM], adv[OFS_SECONDS_COUNT])
            && alarm_match(q.tk[OFS_MINUTES_ALARM], adv[OFS_MINUTES_COUNT])
            && alarm_match(q.tk[OFS_HOURS_ALARM], adv[OFS_HOURS_COUNT]);
    end

    // ********************************
    // read mux
    // ********************************
    always_comb begin
        rd_val = 8'h00;
        if (!bus.a0) begin
            rd_val = {2'h0, q.index};
        end else if (q.index < NUM_TIME_LOCS) begin
            rd_val = q.tk[q.index[3:0]];
        end else begin
            case (q.index)
                OFS_RATE_CONTROL: rd_val = {1'b0, q.ra[6:0]};
                OFS_MODE_CONTROL: rd_val = q.rb;
                // snapshot keeps the byte steady for the whole read
                OFS_EVENT_STATUS: rd_val = q.reading ? {q.snap, 4'h0}
                    : {irq, q.flags, 4'h0};
                OFS_VALID_STATUS: rd_val = VALID_STATUS_VAL;
                default: rd_val = 8'h00;
            endcase
        end
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        d = q;
        if (ce) begin
            d.wr_low = !bus.wr_n;
            d.rd_low = !bus.rd_n;
            d.dout = rd_val;
            if (osc_hold) begin
                d.div = '0;
            end else if (tick_en) begin
                d.div = q.div + 15'h1;
            end
            d.sq = q.rb[RB_SQUARE_EN] && (rate != 4'h0) && q.div[tap_sel];
            if (sec_pulse) begin
                d.tk = adv;
            end
            // events land in the flags, or in pend while a read is open; enables only gate the pin
            if (rd_end) begin
                d.flags = (q.flags & ~q.snap[2:0]) | q.pend | ev;
                d.pend = 3'h0;
                d.reading = 1'b0;
            end else if (q.reading) begin
                d.pend = q.pend | ev;
            end else begin
                d.flags = q.flags | ev;
            end
            if (rd_start) begin
                d.reading = 1'b1;
                d.snap = {irq, q.flags};
                d.pend = ev;
                d.flags = q.flags;
            end
            if (wr_edge) begin
                if (!bus.a0) begin
                    d.index = bus.data[5:0];
                end else if (q.index < NUM_TIME_LOCS) begin
                    d.tk[q.index[3:0]] = bus.data;
                    if (q.index == OFS_SECONDS_COUNT) begin
                        d.tk[OFS_SECONDS_COUNT][7] = 1'b0;
                    end
                end else if (q.index == OFS_RATE_CONTROL) begin
                    d.ra = {1'b0, bus.data[6:0]};
                end else if (q.index == OFS_MODE_CONTROL) begin
                    d.rb = bus.data;
                    if (bus.data[RB_SET]) begin
                        d.rb[F_UPDATE + 4] = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign irq = |(q.flags & q.rb[6:4]);
    assign irq_oe = irq;
    assign irq_n_out = 1'b0;
    assign data_out = q.dout;
    assign data_oe = !bus.sel_n && !bus.rd_n;
    assign square_out_pin = q.sq;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ev_in_read;
        ce && q.reading && ev[F_PERIODIC] && !rd_end;
    endsequence

    sequence s_read_close;
        ce && rd_end;
    endsequence

    property p_gate;
        (!q.rb[6] && !(q.flags[F_ALARM] && q.rb[5]) && !(q.flags[F_UPDATE] && q.rb[4]))
            |-> !irq_oe;
    endproperty
    a_gate: assert property (p_gate) else $error("request without enabled flag");

    property p_level;
        (q.flags[F_ALARM] && q.rb[5]) |-> (irq_oe && !irq_n_out);
    endproperty
    a_level: assert property (p_level) else $error("request not driven low");

    property p_flag_set;
        (ce && |ev && !q.reading && !rd_start) |=> ((q.flags & $past(ev)) == $past(ev));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag not set");

    property p_read_clear;
        s_read_close |=> ((q.flags & $past(q.snap[2:0]) & ~$past(q.pend | ev)) == 3'h0);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag survived read");

    property p_hold;
        s_ev_in_read |=> q.pend[F_PERIODIC];
    endproperty
    a_hold: assert property (p_hold) else $error("event during read lost");

    property p_post;
        (s_read_close and (q.pend[F_PERIODIC] && q.rb[6]))
            |=> (q.flags[F_PERIODIC] && irq_oe);
    endproperty
    a_post: assert property (p_post) else $error("held event not posted");

    property p_summary;
        (ce && rd_start) |=> (data_out[RC_IRQ_SUMMARY] == $past(irq_oe));
    endproperty
    a_summary: assert property (p_summary) else $error("bit 7 differs from request");

    property p_run;
        (ce && osc_tick && q.ra[6:4] == OSC_RUN) |=> (q.div == 15'($past(q.div) + 15'h1));
    endproperty
    a_run: assert property (p_run) else $error("chain did not advance");

    property p_hold_chain;
        (ce && osc_hold) |=> (q.div == 15'h0);
    endproperty
    a_hold_chain: assert property (p_hold_chain) else $error("chain not held");

    property p_stopped;
        (q.ra[6:4] != OSC_RUN && !osc_hold) |=> $stable(q.div);
    endproperty
    a_stopped: assert property (p_stopped) else $error("divider moved while stopped");

    property p_sq_off;
        (ce && !q.rb[RB_SQUARE_EN]) |=> !square_out_pin;
    endproperty
    a_sq_off: assert property (p_sq_off) else $error("square wave while disabled");

    property p_rate_zero;
        (rate == 4'h0) |-> !ev[F_PERIODIC];
    endproperty
    a_rate_zero: assert property (p_rate_zero) else $error("periodic event at rate 0");

    property p_alarm;
        (sec_pulse && alarm_hit && !q.reading && !rd_start) |=> q.flags[F_ALARM];
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm flag missed");
endmodule : rtc_core
`default_nettype wire

// ===== hw/rtc_pkg.sv
package rtc_pkg;
    // ********************************
    // location map
    // ********************************
    localparam logic [5:0] OFS_SECONDS_COUNT = 6'h00;
    localparam logic [5:0] OFS_SECONDS_ALARM = 6'h01;
    localparam logic [5:0] OFS_MINUTES_COUNT = 6'h02;
    localparam logic [5:0] OFS_MINUTES_ALARM = 6'h03;
    localparam logic [5:0] OFS_HOURS_COUNT = 6'h04;
    localparam logic [5:0] OFS_HOURS_ALARM = 6'h05;
    localparam logic [5:0] OFS_WEEKDAY_COUNT = 6'h06;
    localparam logic [5:0] OFS_DAY_OF_MONTH = 6'h07;
    localparam logic [5:0] OFS_MONTH_COUNT = 6'h08;
    localparam logic [5:0] OFS_YEAR_COUNT = 6'h09;
    localparam logic [5:0] OFS_RATE_CONTROL = 6'h0a;
    localparam logic [5:0] OFS_MODE_CONTROL = 6'h0b;
    localparam logic [5:0] OFS_EVENT_STATUS = 6'h0c;
    localparam logic [5:0] OFS_VALID_STATUS = 6'h0d;
    localparam logic [5:0] NUM_TIME_LOCS = 6'h0a;
    // ********************************
    // field positions and codes
    // ********************************
    localparam int RB_SET = 7;
    localparam int RB_SQUARE_EN = 3;
    localparam int RB_BINARY = 2;
    localparam int RB_H24 = 1;
    localparam int RC_IRQ_SUMMARY = 7;
    localparam int F_PERIODIC = 2;
    localparam int F_ALARM = 1;
    localparam int F_UPDATE = 0;
    localparam logic [2:0] OSC_RUN = 3'h2;
    localparam logic [1:0] OSC_HOLD = 2'h3;
    localparam logic [1:0] ALARM_DONT_CARE = 2'h3;
    localparam logic [7:0] VALID_STATUS_VAL = 8'h80;
    localparam int DIV_STAGES = 15;
    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic sel_n;
        logic rd_n;
        logic wr_n;
        logic a0;
        logic [7:0] data;
    } rtc_bus_s;

    typedef struct packed {
        logic [5:0] index;
        logic [9:0][7:0] tk;
        logic [7:0] ra;
        logic [7:0] rb;
        logic [2:0] flags;
        logic [2:0] pend;
        logic [3:0] snap;
        logic reading;
        logic wr_low;
        logic rd_low;
        logic [DIV_STAGES-1:0] div;
        logic [7:0] dout;
        logic sq;
    } rtc_state_s;
endpackage : rtc_pkg

// ===== tb/rtc_host.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// host on the parallel bus
// ********************************
module rtc_host (
    input wire logic clk,
    input wire logic [7:0] data_out,
    output var rtc_pkg::rtc_bus_s bus
);
    import rtc_pkg::*;
    initial begin
        bus = '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: 1'b0, data: 8'h00};
    end
    // one strobe: low one clk, high one clk, select held over the taking edge
    task automatic put(input logic a, input logic [7:0] d);
        @(negedge clk);
        bus.sel_n = 1'b0;
        bus.a0 = a;
        bus.data = d;
        bus.wr_n = 1'b0;
        @(negedge clk);
        bus.wr_n = 1'b1;
        @(negedge clk);
        bus.sel_n = 1'b1;
        // released lines must not keep the last value
        bus.data = ~d;
    endtask : put
    task automatic write_loc(input logic [5:0] idx, input logic [7:0] val);
        put(1'b0, {2'h0, idx});
        put(1'b1, val);
    endtask : write_loc
    // hold keeps the read strobe low longer, to see the byte stand
    task automatic read_loc(input logic [5:0] idx, input int hold, output logic [7:0] v,
                            output logic [7:0] v_end);
        put(1'b0, {2'h0, idx});
        @(negedge clk);
        bus.sel_n = 1'b0;
        bus.a0 = 1'b1;
        bus.rd_n = 1'b0;
        repeat (2) @(negedge clk);
        v = data_out;
        repeat (hold) @(negedge clk);
        v_end = data_out;
        bus.rd_n = 1'b1;
        @(negedge clk);
        bus.sel_n = 1'b1;
    endtask : read_loc
endmodule : rtc_host
`default_nettype wire

// ===== tb/rtc_interrupt_osc_rate_logic_bench.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_interrupt_osc_rate_logic_bench;
    import rtc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_tick = 1'b0;
    logic tick_en = 1'b0;
    logic ce = 1'b1;
    rtc_bus_s bus;
    logic [7:0] data_out;
    logic data_oe;
    logic irq_n_out;
    logic irq_oe;
    logic square_out_pin;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] lf = 8'h30;
    logic [7:0] mem [10];
    logic [15:0] n;
    logic [3:0] rates [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'ha};
    int miscompares = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    // time base pulses every second clk, so all tap periods are twice the tick counts
    always @(negedge clk) osc_tick <= tick_en & ~osc_tick;
    rtc_core dut (.clk(clk), .rst_n(rst_n), .ce(ce), .osc_tick(osc_tick), .bus(bus),
        .data_out(data_out), .data_oe(data_oe), .irq_n_out(irq_n_out), .irq_oe(irq_oe),
        .square_out_pin(square_out_pin));
    rtc_host h (.clk(clk), .data_out(data_out), .bus(bus));
    // the data bus is driven only while selected and read
    always @(posedge clk) begin
        if (rst_n) begin
            chk(data_oe, !bus.sel_n && !bus.rd_n);
        end
    end
    // ********************************
    // helpers
    // ********************************
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt
    function automatic logic [15:0] per(input logic [3:0] r);
        if (r == 4'h0) begin
            return 16'h0;
        end
        return (r < 4'h3) ? 16'h1 << (r + 7) : 16'h1 << r;
    endfunction : per
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // cycles between two rising edges of the square wave, 0 if fewer seen
    task automatic period(output logic [15:0] p);
        logic s;
        int a;
        int b;
        a = -1;
        b = -1;
        s = square_out_pin;
        for (int k = 0; k < 2200; k++) begin
            @(negedge clk);
            if (square_out_pin === 1'b1 && s === 1'b0) begin
                if (a < 0) a = k;
                else if (b < 0) b = k;
            end
            s = square_out_pin;
        end
        p = (b < 0) ? 16'h0 : 16'(b - a);
    endtask : period
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #(25ns * 95000);
        miscompares++;
        summarize();
    end
    // ********************************
    // scenarios
    // ********************************
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        chk(v, 8'h00);
        chk(irq_oe, 1'b0);
        chk(square_out_pin, 1'b0);
        h.read_loc(OFS_RATE_CONTROL, 0, v, w);
        chk(v, 8'h00);
        for (int i = 0; i < 10; i++) begin
            lf = nxt(lf);
            mem[i] = (i == 0) ? {1'b0, lf[6:0]} : lf;
            h.write_loc(6'(i), mem[i]);
        end
        for (int i = 0; i < 10; i++) begin
            h.read_loc(6'(i), 0, v, w);
            chk(v, mem[i]);
        end
        tick_en = 1'b1;
        for (int p = 0; p < 8; p++) begin
            h.write_loc(OFS_RATE_CONTROL, {1'b0, 3'(p), 4'h3});
            h.read_loc(OFS_EVENT_STATUS, 0, v, w);
            repeat (40) @(negedge clk);
            h.read_loc(OFS_EVENT_STATUS, 0, v, w);
            chk(v & 8'h40, (p == 2) ? 8'h40 : 8'h00);
        end
        h.write_loc(OFS_MODE_CONTROL, 8'h08);
        for (int i = 0; i < 6; i++) begin
            h.write_loc(OFS_RATE_CONTROL, {4'h2, rates[i]});
            h.read_loc(OFS_EVENT_STATUS, 0, v, w);
            period(n);
            chk(n, per(rates[i]));
            h.read_loc(OFS_EVENT_STATUS, 0, v, w);
            chk(v[6], rates[i] != 4'h0);
        end
        // clock enable low must freeze the square wave mid-period
        h.write_loc(OFS_RATE_CONTROL, 8'h23);
        ce = 1'b0;
        w = {7'h0, square_out_pin};
        for (int k = 0; k < 20; k++) begin
            @(negedge clk);
            chk(square_out_pin, w[0]);
        end
        ce = 1'b1;
        h.write_loc(OFS_MODE_CONTROL, 8'h00);
        h.write_loc(OFS_RATE_CONTROL, 8'h23);
        period(n);
        chk(n, 16'h0);
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        repeat (20) @(negedge clk);
        chk(irq_oe, 1'b0);
        tick_en = 1'b0;
        repeat (4) @(negedge clk);
        h.write_loc(OFS_MODE_CONTROL, 8'h40);
        chk(irq_oe, 1'b1);
        chk(irq_n_out, 1'b0);
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        chk(v, 8'hc0);
        @(negedge clk);
        chk(irq_oe, 1'b0);
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        chk(v, 8'h00);
        // periodic enable on, so a held event must reach the pin at read end
        h.write_loc(OFS_MODE_CONTROL, 8'h40);
        tick_en = 1'b1;
        h.read_loc(OFS_EVENT_STATUS, 30, v, w);
        chk(v, w);
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        chk(v & 8'h40, 8'h40);
        h.write_loc(OFS_RATE_CONTROL, 8'h60);
        h.write_loc(OFS_SECONDS_COUNT, 8'h00);
        h.write_loc(OFS_SECONDS_ALARM, 8'h01);
        h.write_loc(OFS_MINUTES_ALARM, 8'hc0);
        h.write_loc(OFS_HOURS_ALARM, 8'hff);
        h.write_loc(OFS_MODE_CONTROL, 8'h20);
        h.write_loc(OFS_RATE_CONTROL, 8'h20);
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        for (int k = 0; k < 70000 && irq_oe !== 1'b1; k++) begin
            @(negedge clk);
        end
        chk(irq_oe, 1'b1);
        h.read_loc(OFS_EVENT_STATUS, 0, v, w);
        chk(v, 8'hb0);
        h.read_loc(OFS_SECONDS_COUNT, 0, v, w);
        chk(v, 8'h01);
        summarize();
    end
endmodule : rtc_interrupt_osc_rate_logic_bench
`default_nettype wire
